/* File: include/tmc_pkg.sv */
package tmc_pkg;

    // register offsets on the software port
    localparam logic [7:0] TMC_OFS_RUN_CTRL = 8'h8e;
    localparam logic [7:0] TMC_OFS_MODE01 = 8'h89;
    localparam logic [7:0] TMC_OFS_PAIR01_BASE = 8'h8a;
    localparam logic [7:0] TMC_OFS_MODE34 = 8'h91;
    localparam logic [7:0] TMC_OFS_PAIR34_BASE = 8'h92;
    localparam logic [7:0] TMC_OFS_T2_CTRL = 8'hc8;
    localparam logic [7:0] TMC_OFS_T2_CAP_LO = 8'hca;
    localparam logic [7:0] TMC_OFS_T2_CAP_HI = 8'hcb;
    localparam logic [7:0] TMC_OFS_T2_CNT_LO = 8'hcc;
    localparam logic [7:0] TMC_OFS_T2_CNT_HI = 8'hcd;

    // run control register bits
    localparam int TMC_RUN0_BIT = 0;
    localparam int TMC_RUN1_BIT = 1;
    localparam int TMC_RUN3_BIT = 2;
    localparam int TMC_RUN4_BIT = 3;

    // mode byte fields, low timer in bits 3:0, high timer in bits 7:4
    localparam int TMC_MODE_LSB_LO = 0;
    localparam int TMC_CTR_BIT_LO = 2;
    localparam int TMC_GATE_BIT_LO = 3;
    localparam int TMC_MODE_LSB_HI = 4;
    localparam int TMC_CTR_BIT_HI = 6;
    localparam int TMC_GATE_BIT_HI = 7;

    // timer 2 control and status bits
    localparam int TMC_T2_OVF_BIT = 7;
    localparam int TMC_T2_EXT_BIT = 6;
    localparam int TMC_T2_RCLK_BIT = 5;
    localparam int TMC_T2_SERIAL_TX_CLOCK_SELECT_BIT = 4;
    localparam int TMC_T2_EXEN_BIT = 3;
    localparam int TMC_T2_RUN_BIT = 2;
    localparam int TMC_T2_CT_BIT = 1;
    localparam int TMC_T2_CPRL_BIT = 0;

    // reset values
    localparam logic [7:0] TMC_RST_BYTE = 8'h00;
    localparam logic [15:0] TMC_RST_WORD = 16'h0000;

    typedef enum logic [1:0] {
        TMC_MODE_13 = 2'b00,
        TMC_MODE_16 = 2'b01,
        TMC_MODE_RELOAD = 2'b10,
        TMC_MODE_SPLIT = 2'b11
    } tmc_mode_t;

endpackage : tmc_pkg

/* File: rtl/tmc_timer_pair.sv */
`timescale 1ns/100ps
module tmc_timer_pair
    import tmc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] mode_in,
    input wire logic run_lo_in,
    input wire logic run_hi_in,
    input wire logic gate_lo_in,
    input wire logic gate_hi_in,
    input wire logic event_lo_in,
    input wire logic event_hi_in,
    input wire logic wr_in,
    input wire logic [1:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] tl_lo_out,
    output logic [7:0] tl_hi_out,
    output logic [7:0] th_lo_out,
    output logic [7:0] th_hi_out,
    output logic ovf_lo_out,
    output logic ovf_hi_out,
    output logic ovf_split_out
);

    function automatic logic [16:0] tmc_step(input tmc_mode_t md, input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        unique case (md)
            TMC_MODE_13: tmc_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
            TMC_MODE_16: tmc_step = s16;
            TMC_MODE_RELOAD: tmc_step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
            TMC_MODE_SPLIT: tmc_step = {s8[8], hi, s8[7:0]};
        endcase
    endfunction : tmc_step

    tmc_mode_t mode_lo;
    tmc_mode_t mode_hi;
    logic ev_lo_q;
    logic ev_hi_q;
    logic run_lo;
    logic run_hi;
    logic tick_lo;
    logic tick_hi;
    logic tick_split;
    logic [16:0] res_lo;
    logic [16:0] res_hi;

    assign mode_lo = tmc_mode_t'(mode_in[TMC_MODE_LSB_LO +: 2]);
    assign mode_hi = tmc_mode_t'(mode_in[TMC_MODE_LSB_HI +: 2]);
    // gated: runs only while the pin is high and the run bit is set
    assign run_lo = run_lo_in & (~mode_in[TMC_GATE_BIT_LO] | gate_lo_in);
    assign run_hi = run_hi_in & (~mode_in[TMC_GATE_BIT_HI] | gate_hi_in)
                    & (mode_hi != TMC_MODE_SPLIT);
    assign tick_lo = run_lo & (~mode_in[TMC_CTR_BIT_LO] | (ev_lo_q & ~event_lo_in));
    assign tick_hi = run_hi & (~mode_in[TMC_CTR_BIT_HI] | (ev_hi_q & ~event_hi_in));
    // in split mode the low pair's high byte borrows the high timer's run bit
    assign tick_split = run_hi_in & (mode_lo == TMC_MODE_SPLIT);
    assign res_lo = tmc_step(mode_lo, tl_lo_out, th_lo_out);
    assign res_hi = tmc_step(mode_hi, tl_hi_out, th_hi_out);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ev_lo_q <= 1'b0;
            ev_hi_q <= 1'b0;
        end else begin
            ev_lo_q <= event_lo_in;
            ev_hi_q <= event_hi_in;
        end
    end

    // a software write to a byte wins over counting it in the same cycle
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tl_lo_out <= TMC_RST_BYTE;
            th_lo_out <= TMC_RST_BYTE;
        end else begin
            if (wr_in && wr_idx_in == 2'h0) begin
                tl_lo_out <= wr_data_in;
            end else if (tick_lo) begin
                tl_lo_out <= res_lo[7:0];
            end
            if (wr_in && wr_idx_in == 2'h2) begin
                th_lo_out <= wr_data_in;
            end else if (mode_lo == TMC_MODE_SPLIT) begin
                if (tick_split) begin
                    th_lo_out <= th_lo_out + 8'h01;
                end
            end else if (tick_lo) begin
                th_lo_out <= res_lo[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tl_hi_out <= TMC_RST_BYTE;
            th_hi_out <= TMC_RST_BYTE;
        end else begin
            if (wr_in && wr_idx_in == 2'h1) begin
                tl_hi_out <= wr_data_in;
            end else if (tick_hi) begin
                tl_hi_out <= res_hi[7:0];
            end
            if (wr_in && wr_idx_in == 2'h3) begin
                th_hi_out <= wr_data_in;
            end else if (tick_hi) begin
                th_hi_out <= res_hi[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ovf_lo_out <= 1'b0;
            ovf_hi_out <= 1'b0;
            ovf_split_out <= 1'b0;
        end else begin
            ovf_lo_out <= tick_lo & res_lo[16];
            ovf_hi_out <= tick_hi & res_hi[16];
            ovf_split_out <= tick_split & (th_lo_out == 8'hff);
        end
    end

endmodule : tmc_timer_pair

/* File: rtl/tmc_top.sv */
// Strobed register access was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - low timer mode from mode bits 1:0
// - bit 2 counts falling edges on event pin
// - bit 3 gates low timer with its pin
// - run bit starts and stops timer
// - high timer mode from bits 5:4, 3 halts
// - bit 7 gates high timer with its pin
// - bit 6 counter for high timer, mode 3 halts
// - overflow flag set, never in baud mode
// - interrupt request while enabled flag is set
// - receive clock from timer2 or timer1 overflow
// - transmit clock from timer2 or timer1 overflow
// - trigger edge honoured only if enabled, not baud
// - run bit runs timer2
// - counter select picks clock or event edges
// - select bit picks reload or capture mode
module tmc_top
    import tmc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic low_timer_gate_pin_in,
    input wire logic high_timer_gate_pin_in,
    input wire logic third_timer_gate_pin_in,
    input wire logic fourth_timer_gate_pin_in,
    input wire logic [3:0] timer_event_in,
    input wire logic t2_event_input_in,
    input wire logic t2_trigger_pin_in,
    input wire logic t2_irq_enable_in,
    output logic t2_irq_out,
    output logic [5:0] timer_ovf_out,
    output logic serial_rx_clock_out,
    output logic serial_tx_clock_out
);

    logic [7:0] timer01_mode_byte;
    logic [7:0] timer34_mode_byte;
    logic low_timer_run_bit;
    logic high_timer_run_bit;
    logic third_timer_run_bit;
    logic fourth_timer_run_bit;

    logic t2_overflow_flag;
    logic t2_external_flag;
    logic serial_rx_clock_select;
    logic serial_tx_clock_select;
    logic t2_external_enable;
    logic t2_run_bit;
    logic t2_counter_select;
    logic t2_capture_reload_select;
    logic [15:0] t2_count;
    logic [15:0] t2_capture;

    logic [7:0] p01_tl_lo;
    logic [7:0] p01_tl_hi;
    logic [7:0] p01_th_lo;
    logic [7:0] p01_th_hi;
    logic [7:0] p34_tl_lo;
    logic [7:0] p34_tl_hi;
    logic [7:0] p34_th_lo;
    logic [7:0] p34_th_hi;
    logic p01_wr;
    logic p34_wr;
    logic [7:0] t2_ctrl_value;
    logic [7:0] next_rdata;

    logic t2_ev_q;
    logic t2_trig_q;
    logic t2_baud;
    logic t2_tick;
    logic t2_wrap;
    logic t2_trig_event;
    logic t2_do_capture;
    logic t2_do_reload;
    logic t2_ovf_pulse;
    logic t2_ctrl_wr;

    // pair bytes sit at base to base+3 in the order tl_lo, tl_hi, th_lo, th_hi
    assign p01_wr = reg_wr_in && (reg_addr_in - TMC_OFS_PAIR01_BASE < 8'h04);
    assign p34_wr = reg_wr_in && (reg_addr_in - TMC_OFS_PAIR34_BASE < 8'h04);
    assign t2_ctrl_wr = reg_wr_in && (reg_addr_in == TMC_OFS_T2_CTRL);

    tmc_timer_pair u_pair01 (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .mode_in(timer01_mode_byte),
        .run_lo_in(low_timer_run_bit),
        .run_hi_in(high_timer_run_bit),
        .gate_lo_in(low_timer_gate_pin_in),
        .gate_hi_in(high_timer_gate_pin_in),
        .event_lo_in(timer_event_in[0]),
        .event_hi_in(timer_event_in[1]),
        .wr_in(p01_wr),
        .wr_idx_in(reg_addr_in[1:0] - TMC_OFS_PAIR01_BASE[1:0]),
        .wr_data_in(reg_wdata_in),
        .tl_lo_out(p01_tl_lo),
        .tl_hi_out(p01_tl_hi),
        .th_lo_out(p01_th_lo),
        .th_hi_out(p01_th_hi),
        .ovf_lo_out(timer_ovf_out[0]),
        .ovf_hi_out(timer_ovf_out[1]),
        .ovf_split_out(timer_ovf_out[2])
    );

    tmc_timer_pair u_pair34 (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .mode_in(timer34_mode_byte),
        .run_lo_in(third_timer_run_bit),
        .run_hi_in(fourth_timer_run_bit),
        .gate_lo_in(third_timer_gate_pin_in),
        .gate_hi_in(fourth_timer_gate_pin_in),
        .event_lo_in(timer_event_in[2]),
        .event_hi_in(timer_event_in[3]),
        .wr_in(p34_wr),
        .wr_idx_in(reg_addr_in[1:0] - TMC_OFS_PAIR34_BASE[1:0]),
        .wr_data_in(reg_wdata_in),
        .tl_lo_out(p34_tl_lo),
        .tl_hi_out(p34_tl_hi),
        .th_lo_out(p34_th_lo),
        .th_hi_out(p34_th_hi),
        .ovf_lo_out(timer_ovf_out[3]),
        .ovf_hi_out(timer_ovf_out[4]),
        .ovf_split_out(timer_ovf_out[5])
    );

    // mode bytes and run bits
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            timer01_mode_byte <= TMC_RST_BYTE;
            timer34_mode_byte <= TMC_RST_BYTE;
            low_timer_run_bit <= 1'b0;
            high_timer_run_bit <= 1'b0;
            third_timer_run_bit <= 1'b0;
            fourth_timer_run_bit <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == TMC_OFS_MODE01) begin
                timer01_mode_byte <= reg_wdata_in;
            end
            if (reg_addr_in == TMC_OFS_MODE34) begin
                timer34_mode_byte <= reg_wdata_in;
            end
            if (reg_addr_in == TMC_OFS_RUN_CTRL) begin
                low_timer_run_bit <= reg_wdata_in[TMC_RUN0_BIT];
                high_timer_run_bit <= reg_wdata_in[TMC_RUN1_BIT];
                third_timer_run_bit <= reg_wdata_in[TMC_RUN3_BIT];
                fourth_timer_run_bit <= reg_wdata_in[TMC_RUN4_BIT];
            end
        end
    end

    // timer 2 datapath
    assign t2_baud = serial_rx_clock_select | serial_tx_clock_select;
    assign t2_tick = t2_run_bit & (~t2_counter_select | (t2_ev_q & ~t2_event_input_in));
    assign t2_wrap = t2_tick & (t2_count == 16'hffff);
    // baud mode masks the trigger pin so the bit clock is never disturbed
    assign t2_trig_event = t2_external_enable & ~t2_baud
                           & t2_trig_q & ~t2_trigger_pin_in;
    assign t2_do_capture = t2_trig_event & t2_capture_reload_select;
    assign t2_do_reload = t2_wrap & (t2_baud | ~t2_capture_reload_select)
                          | t2_trig_event & ~t2_capture_reload_select;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            t2_ev_q <= 1'b0;
            t2_trig_q <= 1'b0;
        end else begin
            t2_ev_q <= t2_event_input_in;
            t2_trig_q <= t2_trigger_pin_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            t2_count <= TMC_RST_WORD;
        end else if (reg_wr_in && reg_addr_in == TMC_OFS_T2_CNT_LO) begin
            t2_count[7:0] <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == TMC_OFS_T2_CNT_HI) begin
            t2_count[15:8] <= reg_wdata_in;
        end else if (t2_do_reload) begin
            t2_count <= t2_capture;
        end else if (t2_tick) begin
            t2_count <= t2_count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            t2_capture <= TMC_RST_WORD;
        end else if (reg_wr_in && reg_addr_in == TMC_OFS_T2_CAP_LO) begin
            t2_capture[7:0] <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == TMC_OFS_T2_CAP_HI) begin
            t2_capture[15:8] <= reg_wdata_in;
        end else if (t2_do_capture) begin
            t2_capture <= t2_count;
        end
    end

    // control bits; hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            serial_rx_clock_select <= 1'b0;
            serial_tx_clock_select <= 1'b0;
            t2_external_enable <= 1'b0;
            t2_run_bit <= 1'b0;
            t2_counter_select <= 1'b0;
            t2_capture_reload_select <= 1'b0;
        end else if (t2_ctrl_wr) begin
            serial_rx_clock_select <= reg_wdata_in[TMC_T2_RCLK_BIT];
            serial_tx_clock_select <= reg_wdata_in[TMC_T2_SERIAL_TX_CLOCK_SELECT_BIT];
            t2_external_enable <= reg_wdata_in[TMC_T2_EXEN_BIT];
            t2_run_bit <= reg_wdata_in[TMC_T2_RUN_BIT];
            t2_counter_select <= reg_wdata_in[TMC_T2_CT_BIT];
            t2_capture_reload_select <= reg_wdata_in[TMC_T2_CPRL_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            t2_overflow_flag <= 1'b0;
            t2_external_flag <= 1'b0;
        end else begin
            t2_overflow_flag <= (t2_ctrl_wr ? reg_wdata_in[TMC_T2_OVF_BIT] : t2_overflow_flag)
                                | (t2_wrap & ~t2_baud);
            t2_external_flag <= (t2_ctrl_wr ? reg_wdata_in[TMC_T2_EXT_BIT] : t2_external_flag)
                                | t2_trig_event;
        end
    end

    assign t2_irq_out = t2_irq_enable_in & (t2_external_flag | t2_overflow_flag);

    // serial bit clocks, one pulse per selected overflow
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            t2_ovf_pulse <= 1'b0;
            serial_rx_clock_out <= 1'b0;
            serial_tx_clock_out <= 1'b0;
        end else begin
            t2_ovf_pulse <= t2_wrap;
            serial_rx_clock_out <= serial_rx_clock_select ? t2_wrap : timer_ovf_out[1];
            serial_tx_clock_out <= serial_tx_clock_select ? t2_wrap : timer_ovf_out[1];
        end
    end

    assign t2_ctrl_value = {t2_overflow_flag, t2_external_flag, serial_rx_clock_select,
                            serial_tx_clock_select, t2_external_enable, t2_run_bit,
                            t2_counter_select, t2_capture_reload_select};

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr_in)
            TMC_OFS_MODE01: next_rdata = timer01_mode_byte;
            TMC_OFS_MODE34: next_rdata = timer34_mode_byte;
            TMC_OFS_RUN_CTRL: next_rdata = {4'h0, fourth_timer_run_bit, third_timer_run_bit,
                                            high_timer_run_bit, low_timer_run_bit};
            8'h8a: next_rdata = p01_tl_lo;
            8'h8b: next_rdata = p01_tl_hi;
            8'h8c: next_rdata = p01_th_lo;
            8'h8d: next_rdata = p01_th_hi;
            8'h92: next_rdata = p34_tl_lo;
            8'h93: next_rdata = p34_tl_hi;
            8'h94: next_rdata = p34_th_lo;
            8'h95: next_rdata = p34_th_hi;
            TMC_OFS_T2_CTRL: next_rdata = t2_ctrl_value;
            TMC_OFS_T2_CAP_LO: next_rdata = t2_capture[7:0];
            TMC_OFS_T2_CAP_HI: next_rdata = t2_capture[15:8];
            TMC_OFS_T2_CNT_LO: next_rdata = t2_count[7:0];
            TMC_OFS_T2_CNT_HI: next_rdata = t2_count[15:8];
            default: next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
        end
    end

endmodule : tmc_top

/* File: tb/tmc_top_props.sv */
`timescale 1ns/100ps
module tmc_top_props
    import tmc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic low_timer_gate_pin_in,
    input wire logic t2_irq_enable_in,
    input wire logic t2_irq_out,
    input wire logic [5:0] timer_ovf_out,
    input wire logic serial_rx_clock_out,
    input wire logic serial_tx_clock_out
);
    // software-only shadows
    logic [7:0] ctl;
    logic [7:0] md;
    logic [7:0] run;
    logic wr_ctl;
    assign wr_ctl = reg_wr_in && (reg_addr_in == TMC_OFS_T2_CTRL);
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctl <= 8'h00;
            md <= 8'h00;
            run <= 8'h00;
        end else if (reg_wr_in) begin
            if (reg_addr_in == TMC_OFS_T2_CTRL) ctl <= reg_wdata_in;
            if (reg_addr_in == TMC_OFS_MODE01) md <= reg_wdata_in;
            if (reg_addr_in == TMC_OFS_RUN_CTRL) run <= reg_wdata_in;
        end
    end
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_irq_off;
        !t2_irq_enable_in |-> !t2_irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_flag_hold;
        t2_irq_out && t2_irq_enable_in && !wr_ctl |=> t2_irq_out || !t2_irq_enable_in;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
    property p_baud_noflag;
        (ctl[5] || ctl[4]) && t2_irq_enable_in && !t2_irq_out && !wr_ctl |=> !t2_irq_out;
    endproperty
    a_baud_noflag: assert property (p_baud_noflag) else $error("flag in baud mode");
    property p_no_ext;
        !ctl[3] && !ctl[2] && t2_irq_enable_in && !t2_irq_out && !wr_ctl |=> !t2_irq_out;
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("trigger not ignored");
    property p_rx_t1;
        !ctl[5] |=> serial_rx_clock_out == $past(timer_ovf_out[1]);
    endproperty
    a_rx_t1: assert property (p_rx_t1) else $error("rx clock not timer1");
    property p_tx_t1;
        !ctl[4] |=> serial_tx_clock_out == $past(timer_ovf_out[1]);
    endproperty
    a_tx_t1: assert property (p_tx_t1) else $error("tx clock not timer1");
    property p_gate;
        (md[3] && !low_timer_gate_pin_in) [*2] |-> !timer_ovf_out[0];
    endproperty
    a_gate: assert property (p_gate) else $error("gated timer ran");
    property p_run_off;
        (!run[0]) [*2] |-> !timer_ovf_out[0];
    endproperty
    a_run_off: assert property (p_run_off) else $error("stopped timer ran");
    property p_hi_halt;
        (md[5:4] == 2'b11) [*2] |-> !timer_ovf_out[1];
    endproperty
    a_hi_halt: assert property (p_hi_halt) else $error("high timer mode 3 ran");
endmodule : tmc_top_props

bind tmc_top tmc_top_props u_props (.ref_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .low_timer_gate_pin_in, .t2_irq_enable_in, .t2_irq_out, .timer_ovf_out,
    .serial_rx_clock_out, .serial_tx_clock_out);

/* File: tb/tmc_pin_model.sv */
`timescale 1ns/100ps
module tmc_pin_model (
    input wire logic ref_clk_in,
    output logic [3:0] gate_pins_out,
    output logic [5:0] fall_lines_out
);
    // lines rest high as with pull-ups: [3:0] timer events, [4] t2 event, [5] trigger
    initial begin
        gate_pins_out = 4'hf;
        fall_lines_out = 6'h3f;
    end
    // held low three cycles
    task automatic fall(input int sel);
        @(posedge ref_clk_in);
        fall_lines_out[sel] <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        fall_lines_out[sel] <= 1'b1;
    endtask : fall
    task automatic set_gate(input int idx, input logic v);
        @(posedge ref_clk_in);
        gate_pins_out[idx] <= v;
    endtask : set_gate
endmodule : tmc_pin_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import tmc_pkg::*;
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
    logic ref_clk_in, nrst_in, reg_wr_in, reg_rd_in, t2_irq_enable_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ma, lo, rb;
    logic t2_irq_out, serial_rx_clock_out, serial_tx_clock_out;
    logic [5:0] timer_ovf_out, fall_lines;
    logic [3:0] gate_pins;
    int err_total, tests_run, n, oi, rxn, txn;
    logic [7:0] mlo [4] = '{8'hfd, 8'hfe, 8'h1e, 8'hfe};
    logic [7:0] mhi [4] = '{8'hff, 8'hf0, 8'hff, 8'hff};
    logic [7:0] mcode [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
    int mexp [4] = '{4, 3, 3, 3};
    localparam logic [7:0] CT = TMC_OFS_T2_CTRL, CL = TMC_OFS_T2_CNT_LO, CH = TMC_OFS_T2_CNT_HI;
    localparam logic [7:0] PL = TMC_OFS_T2_CAP_LO, PH = TMC_OFS_T2_CAP_HI, RC = TMC_OFS_RUN_CTRL;
    localparam logic [7:0] M01 = TMC_OFS_MODE01;
    tmc_pin_model pins (.ref_clk_in, .gate_pins_out(gate_pins), .fall_lines_out(fall_lines));
    tmc_top DUT (.ref_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .low_timer_gate_pin_in(gate_pins[0]),
        .high_timer_gate_pin_in(gate_pins[1]), .third_timer_gate_pin_in(gate_pins[2]),
        .fourth_timer_gate_pin_in(gate_pins[3]), .timer_event_in(fall_lines[3:0]),
        .t2_event_input_in(fall_lines[4]), .t2_trigger_pin_in(fall_lines[5]),
        .t2_irq_enable_in, .t2_irq_out, .timer_ovf_out, .serial_rx_clock_out,
        .serial_tx_clock_out);
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(negedge ref_clk_in) begin
        if (serial_rx_clock_out === 1'b1) rxn++;
        if (serial_tx_clock_out === 1'b1) txn++;
    end
    // strobe stays up between back-to-back writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        reg_wr_in <= 1'b0;
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK($sformatf("reg %h", a), ex, reg_rdata_out)
        @(posedge ref_clk_in);
    endtask : rd
    task automatic idle(input int c);
        reg_wr_in <= 1'b0;
        repeat (c) @(posedge ref_clk_in);
    endtask : idle
    task automatic ev(input int sel);
        reg_wr_in <= 1'b0;
        pins.fall(sel);
    endtask : ev
    task automatic gate(input logic v);
        reg_wr_in <= 1'b0;
        pins.set_gate(0, v);
    endtask : gate
    task automatic chk_irq(input logic ex);
        reg_wr_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK("irq", ex, t2_irq_out)
        @(posedge ref_clk_in);
    endtask : chk_irq
    task automatic wait_bit(input int idx, input int lim, output int cnt);
        cnt = 0;
        reg_wr_in <= 1'b0;
        do begin
            @(negedge ref_clk_in);
            cnt++;
        end while (timer_ovf_out[idx] !== 1'b1 && cnt < lim);
        @(posedge ref_clk_in);
    endtask : wait_bit
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask : done
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_total++;
        close_out();
    end
    initial begin
        nrst_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        t2_irq_enable_in = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (12) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(posedge ref_clk_in);
        rd(CT, 8'h00);
        rd(M01, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        done("reset and map");
        for (int p = 0; p < 2; p++) begin
            ma = p ? TMC_OFS_MODE34 : M01;
            lo = p ? TMC_OFS_PAIR34_BASE : TMC_OFS_PAIR01_BASE;
            rb = p ? 8'h04 : 8'h01;
            oi = p ? 3 : 0;
            for (int m = 0; m < 4; m++) begin
                wr(RC, 8'h00);
                wr(lo, mlo[m]);
                wr(lo + 8'h02, mhi[m]);
                wr(ma, mcode[m]);
                wr(RC, rb);
                wait_bit(oi, 40, n);
                `CHK("ovf latency", mexp[m], n)
                if (m == 1) begin
                    wait_bit(oi, 40, n);
                    `CHK("reload period", 16, n)
                end
            end
        end
        done("low timer modes");
        wr(RC, 8'h00);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        wr(M01, 8'h05);
        wr(RC, 8'h01);
        idle(8);
        rd(8'h8a, 8'hfe);
        ev(0);
        rd(8'h8a, 8'hff);
        gate(1'b0);
        wr(8'h8a, 8'hfd);
        wr(M01, 8'h09);
        wait_bit(0, 30, n);
        `CHK("gated hold", 30, n)
        gate(1'b1);
        wait_bit(0, 10, n);
        `CHK("gate open", 1'b1, n < 10)
        done("counter and gate");
        wr(RC, 8'h00);
        wr(8'h8b, 8'hff);
        wr(8'h8d, 8'hff);
        wr(M01, 8'h30);
        wr(RC, 8'h02);
        wait_bit(1, 40, n);
        `CHK("high halt", 40, n)
        wr(M01, 8'h10);
        wait_bit(1, 10, n);
        `CHK("high 16 bit", 2, n)
        wr(M01, 8'h70);
        wr(8'h8b, 8'hff);
        wr(8'h8d, 8'hff);
        wait_bit(1, 40, n);
        `CHK("counter mode 3", 40, n)
        wr(M01, 8'h50);
        idle(5);
        rd(8'h8b, 8'hff);
        ev(1);
        rd(8'h8b, 8'h00);
        done("high timer");
        wr(RC, 8'h00);
        t2_irq_enable_in <= 1'b1;
        wr(CL, 8'hff);
        wr(CH, 8'hff);
        wr(PL, 8'h34);
        wr(PH, 8'h12);
        wr(CT, 8'h04);
        wr(CT, 8'h80);
        rd(CT, 8'h80);
        rd(CL, 8'h34);
        rd(CH, 8'h12);
        chk_irq(1'b1);
        t2_irq_enable_in <= 1'b0;
        chk_irq(1'b0);
        t2_irq_enable_in <= 1'b1;
        wr(CT, 8'h00);
        chk_irq(1'b0);
        wr(CL, 8'h78);
        wr(CH, 8'h56);
        wr(CT, 8'h09);
        ev(5);
        rd(PL, 8'h78);
        rd(PH, 8'h56);
        rd(CT, 8'h49);
        wr(CT, 8'h08);
        wr(CL, 8'h00);
        wr(CH, 8'h00);
        ev(5);
        rd(CL, 8'h78);
        rd(CT, 8'h48);
        wr(CT, 8'h01);
        wr(PL, 8'h00);
        ev(5);
        rd(PL, 8'h00);
        rd(CT, 8'h01);
        done("timer2 capture reload");
        wr(CL, 8'hff);
        wr(CH, 8'hff);
        wr(PH, 8'h00);
        wr(CT, 8'h06);
        idle(8);
        rd(CL, 8'hff);
        ev(4);
        rd(CL, 8'h00);
        rd(CT, 8'h86);
        wr(CT, 8'h00);
        wr(CL, 8'hff);
        wr(CH, 8'hff);
        wr(PH, 8'hab);
        oi = rxn;
        n = txn;
        wr(CT, 8'h35);
        wr(CT, 8'h31);
        rd(CT, 8'h31);
        rd(CH, 8'hab);
        `CHK("rx clock", 1'b1, rxn > oi)
        `CHK("tx clock", 1'b1, txn > n)
        ev(5);
        rd(CT, 8'h31);
        done("timer2 baud");
        close_out();
    end
endmodule : testbench
